//--- spi_access_pkg.sv
/*
  Shared constants and types for the serial access decoder and its master.
  Assumes both ends run on one 125 MHz clock and meet in spi_link_if.
*/
package spi_access_pkg;

  // header byte layout
  localparam int HDR_RW_BIT = 7;
  localparam int HDR_BURST_BIT = 6;

  // header address map
  localparam logic [5:0] ADDR_EXT = 6'h2F;
  localparam logic [5:0] ADDR_REG_LAST = 6'h2E;
  localparam logic [5:0] STROBE_FIRST = 6'h30;
  localparam logic [5:0] STROBE_LAST = 6'h3D;
  localparam logic [5:0] ADDR_DIRECT = 6'h3E;
  localparam logic [5:0] ADDR_FIFO = 6'h3F;

  // extended and direct address map
  localparam logic [7:0] DIRECT_SPLIT = 8'h80;
  localparam logic [7:0] EXT_PREBUF = 8'hDA;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] STATUS_LOW_BITS = 4'h0;

  // master register port
  localparam logic [3:0] HOST_TX_OFF = 4'h0;
  localparam logic [3:0] HOST_RX_OFF = 4'h4;
  localparam logic [3:0] HOST_STAT_OFF = 4'h8;
  localparam int HOST_LAST_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RX_BIT = 1;
  localparam int STAT_FRAME_BIT = 2;

  // link timing, in ns, and derived clock counts (rounded up)
  localparam int CLOCK_NS = 8;
  localparam int SCLK_HALF_NS = 50;
  localparam int SETUP_NS = 50;
  localparam int HOLD_NS = 200;
  localparam int REST_NS = 50;
  localparam int GAP_NS = 100;
  localparam logic [7:0] HALF_CYC =
    8'((SCLK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [7:0] REST_CYC = 8'((REST_NS + CLOCK_NS - 1) / CLOCK_NS);
  localparam logic [7:0] GAP_CYC = 8'((GAP_NS + CLOCK_NS - 1) / CLOCK_NS);

  // target of one byte access
  typedef enum logic [2:0] {
    SP_REG, SP_EXT, SP_FIFO, SP_DIR_TX, SP_DIR_RX, SP_FEC, SP_FREE
  } space_t;

  typedef enum logic [1:0] {
    ST_HEADER, ST_EXT_ADDR, ST_DIR_ADDR, ST_DATA
  } link_state_t;

  typedef enum logic [2:0] {
    HS_IDLE, HS_READY, HS_LOW, HS_HIGH, HS_GAP, HS_HOLD, HS_REST
  } host_state_t;

endpackage

//--- spi_link_if.sv
/*
  The four-wire serial link between master and decoder.
  Assumes the bench instantiates it once and hands each end its modport.
*/
`timescale 1ns/1ps
interface spi_link_if;
  logic select_low;
  logic sclk;
  logic mosi;
  logic miso;

  modport device (
    input select_low,
    input sclk,
    input mosi,
    output miso
  );

  modport host (
    output select_low,
    output sclk,
    output mosi,
    input miso
  );
endinterface

//--- spi_access_device.sv
/*
  Slave end: decodes header bytes into register, extended, strobe, FIFO
  and direct memory accesses, and drives status or read data back.
  Assumes the user side answers a read in the cycle after acc_valid and
  that sclk stays high at least 4 clock cycles after each rising edge.
*/
`timescale 1ns/1ps
module spi_access_device (
  input wire logic clock,
  input wire logic resetn,
  spi_link_if.device link,
  input wire logic chip_ready_low,
  input wire logic [2:0] main_state,
  input wire logic burst_autoinc_enable,
  input wire logic direct_select,
  input wire logic error_correction_enable,
  input wire logic rx_fifo_empty,
  input wire logic rx_push_valid,
  input wire logic [7:0] rx_push_data,
  output logic acc_valid,
  output logic acc_write,
  output spi_access_pkg::space_t acc_space,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  output logic strobe_valid,
  output logic [5:0] strobe_code
);
  import spi_access_pkg::*;

  logic [1:0] sel_sync;
  logic [1:0] sclk_sync;
  logic [1:0] mosi_sync;
  logic sclk_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic begun_reg;
  link_state_t state_reg, state_next;
  space_t space_reg, space_next;
  logic [7:0] addr_reg, addr_next;
  logic rw_reg, rw_next;
  logic burst_reg, burst_next;
  logic [7:0] tx_reg;
  logic [7:0] next_reg;
  logic [7:0] load_val;
  logic fetch_reg, fetch_wait_reg;
  logic [7:0] prebuf_reg;
  logic acc_valid_reg, acc_write_reg;
  space_t acc_space_reg;
  logic [7:0] acc_addr_reg, acc_wdata_reg;
  logic strobe_valid_reg;
  logic [5:0] strobe_code_reg;
  logic rd_issue, wr_issue, strobe_next;

  // direct memory target from the select bit and the address half
  function automatic space_t dir_space(input logic [7:0] a);
    if (direct_select)
      dir_space = (a >= DIRECT_SPLIT) ? SP_FREE : SP_FEC;
    else
      dir_space = (a >= DIRECT_SPLIT) ? SP_DIR_RX : SP_DIR_TX;
  endfunction

  // link pins cross in through two flops each
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel_sync <= 2'h3;
      sclk_sync <= 2'h0;
      mosi_sync <= 2'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[0], link.select_low};
      sclk_sync <= {sclk_sync[0], link.sclk};
      mosi_sync <= {mosi_sync[0], link.mosi};
      sclk_prev_reg <= sclk_sync[1];
    end
  end

  // edge finding and header field decode
  wire active = !sel_sync[1];
  wire rise = active && sclk_sync[1] && !sclk_prev_reg;
  wire fall = active && !sclk_sync[1] && sclk_prev_reg;
  wire [7:0] rx_byte = {shift_reg, mosi_sync[1]};
  wire byte_done = rise && (bit_cnt_reg == 3'h7);
  wire [7:0] status_byte = {chip_ready_low, main_state, STATUS_LOW_BITS};
  wire hdr_read = rx_byte[HDR_RW_BIT];
  wire hdr_burst = rx_byte[HDR_BURST_BIT];
  wire [5:0] hdr_addr = rx_byte[5:0];
  wire is_reg = hdr_addr < ADDR_EXT;
  wire is_ext = hdr_addr == ADDR_EXT;
  wire is_dir = hdr_addr == ADDR_DIRECT;
  wire is_fifo = hdr_addr == ADDR_FIFO;
  wire is_direct = space_reg inside {SP_DIR_TX, SP_DIR_RX, SP_FEC, SP_FREE};
  // counter holds on FIFO data, at the register-space end, or autoinc off outside direct memory
  wire hold = (space_reg == SP_FIFO)
    || (space_reg == SP_REG && addr_reg == {2'h0, ADDR_REG_LAST})
    || (!burst_autoinc_enable && !is_direct);
  // extended and direct addresses wrap naturally in eight bits
  wire [7:0] inc_addr = hold ? addr_reg : addr_reg + 8'h01;
  // workspace belongs to the error-correction core while it runs
  wire wr_blocked = (space_reg == SP_FEC) && error_correction_enable;

  // byte-boundary decisions of the access decoder
  always_comb begin
    state_next = state_reg;
    space_next = space_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    burst_next = burst_reg;
    load_val = status_byte;
    rd_issue = 1'b0;
    wr_issue = 1'b0;
    strobe_next = 1'b0;
    if (byte_done) begin
      unique case (state_reg)
        ST_HEADER: begin
          rw_next = hdr_read;
          burst_next = hdr_burst;
          addr_next = {2'h0, hdr_addr};
          if (is_reg || is_fifo) begin
            state_next = ST_DATA;
            space_next = is_fifo ? SP_FIFO : SP_REG;
            rd_issue = hdr_read;
          end else if (is_ext) begin
            state_next = ST_EXT_ADDR;
            load_val = ZERO_BYTE;
          end else if (is_dir) begin
            state_next = ST_DIR_ADDR;
          end else begin
            strobe_next = !hdr_burst;
          end
        end
        ST_EXT_ADDR, ST_DIR_ADDR: begin
          addr_next = rx_byte;
          state_next = ST_DATA;
          space_next = (state_reg == ST_EXT_ADDR) ? SP_EXT : dir_space(rx_byte);
          rd_issue = rw_reg;
        end
        ST_DATA: begin
          wr_issue = !rw_reg && !wr_blocked;
          if (burst_reg) begin
            addr_next = inc_addr;
            space_next = is_direct ? dir_space(inc_addr) : space_reg;
            rd_issue = rw_reg;
          end else begin
            state_next = ST_HEADER;
          end
        end
      endcase
    end
  end

  // bit counter, receive shifter and decoder state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
      begun_reg <= 1'b0;
      state_reg <= ST_HEADER;
      space_reg <= SP_REG;
      addr_reg <= 8'h00;
      rw_reg <= 1'b0;
      burst_reg <= 1'b0;
    end else if (!active) begin
      bit_cnt_reg <= 3'h0;
      begun_reg <= 1'b0;
      state_reg <= ST_HEADER;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= rx_byte[6:0];
      begun_reg <= 1'b1;
      state_reg <= state_next;
      space_reg <= space_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      burst_reg <= burst_next;
    end
  end

  // next outgoing byte; read data taken the cycle after acc_valid
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      next_reg <= 8'h00;
      fetch_wait_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end else begin
      fetch_wait_reg <= rd_issue;
      fetch_reg <= fetch_wait_reg;
      if (fetch_reg)
        next_reg <= (acc_space_reg == SP_EXT && acc_addr_reg == EXT_PREBUF)
          ? prebuf_reg : acc_rdata;
      else if (byte_done)
        next_reg <= load_val;
    end
  end

  // transmit shifter changes on falling edges so the master samples clean
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      tx_reg <= 8'hFF;
    else if (!active || (state_reg == ST_HEADER && !begun_reg))
      tx_reg <= status_byte;
    else if (fall)
      tx_reg <= (bit_cnt_reg == 3'h0) ? next_reg : {tx_reg[6:0], 1'b0};
  end

  // first byte into an empty receive FIFO is kept aside
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      prebuf_reg <= 8'h00;
    else if (rx_push_valid && rx_fifo_empty)
      prebuf_reg <= rx_push_data;
  end

  // user-side access and strobe pulses
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_valid_reg <= 1'b0;
      acc_write_reg <= 1'b0;
      acc_space_reg <= SP_REG;
      acc_addr_reg <= 8'h00;
      acc_wdata_reg <= 8'h00;
      strobe_valid_reg <= 1'b0;
      strobe_code_reg <= 6'h00;
    end else begin
      acc_valid_reg <= rd_issue || wr_issue;
      strobe_valid_reg <= strobe_next;
      if (wr_issue) begin
        acc_write_reg <= 1'b1;
        acc_space_reg <= space_reg;
        acc_addr_reg <= addr_reg;
        acc_wdata_reg <= rx_byte;
      end else if (rd_issue) begin
        acc_write_reg <= 1'b0;
        acc_space_reg <= space_next;
        acc_addr_reg <= addr_next;
      end
      if (strobe_next)
        strobe_code_reg <= hdr_addr;
    end
  end

  assign link.miso = tx_reg[7];
  assign acc_valid = acc_valid_reg;
  assign acc_write = acc_write_reg;
  assign acc_space = acc_space_reg;
  assign acc_addr = acc_addr_reg;
  assign acc_wdata = acc_wdata_reg;
  assign strobe_valid = strobe_valid_reg;
  assign strobe_code = strobe_code_reg;
endmodule

//--- spi_access_host.sv
/*
  Master end: sends bytes that software queues through a small register
  port and returns each byte read back from the link.
  Assumes software polls the status word; no interrupt is raised.
*/
`timescale 1ns/1ps
module spi_access_host (
  input wire logic clock,
  input wire logic resetn,
  spi_link_if.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata
);
  import spi_access_pkg::*;

  logic [1:0] miso_sync;
  host_state_t state_reg;
  logic [7:0] timer_reg;
  logic sel_low_reg, sclk_reg, mosi_reg;
  logic [7:0] out_shift_reg, in_shift_reg;
  logic [2:0] bit_reg;
  logic pend_reg, pend_last_reg, last_reg;
  logic [7:0] pend_byte_reg, rx_reg;
  logic rx_ready_reg;
  logic [15:0] rdata_reg;

  // register decode and link helpers
  wire tick = timer_reg == 8'h00;
  wire wr_tx = reg_write && reg_addr == HOST_TX_OFF && !pend_reg;
  wire rd_rx = reg_read && reg_addr == HOST_RX_OFF;
  wire start = pend_reg && tick
    && ((state_reg == HS_READY && !miso_sync[1])
    || state_reg == HS_GAP);
  wire byte_end = state_reg == HS_HIGH && tick && bit_reg == 3'h7;
  wire [15:0] stat_word = {13'h0000, !sel_low_reg, rx_ready_reg, pend_reg};
  wire [15:0] rd_mux =
    (reg_addr == HOST_RX_OFF) ? {8'h00, rx_reg} :
    (reg_addr == HOST_STAT_OFF) ? {stat_word[15:3], ~stat_word[STAT_FRAME_BIT],
      stat_word[STAT_RX_BIT], stat_word[STAT_BUSY_BIT]} : 16'h0000;

  // miso crosses in through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      miso_sync <= 2'h3;
    else
      miso_sync <= {miso_sync[0], link.miso};
  end

  // software queue, receive holding and read answer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= 1'b0;
      pend_byte_reg <= 8'h00;
      pend_last_reg <= 1'b0;
      rx_reg <= 8'h00;
      rx_ready_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      if (wr_tx) begin
        pend_reg <= 1'b1;
        pend_byte_reg <= reg_wdata[7:0];
        pend_last_reg <= reg_wdata[HOST_LAST_BIT];
      end else if (start) begin
        pend_reg <= 1'b0;
      end
      // a byte ending in the read cycle keeps the flag up
      if (byte_end) begin
        rx_reg <= in_shift_reg;
        rx_ready_reg <= 1'b1;
      end else if (rd_rx) begin
        rx_ready_reg <= 1'b0;
      end
      rdata_reg <= reg_read ? rd_mux : 16'h0000;
    end
  end

  // link sequencer; the timer is the divider for every link phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= HS_IDLE;
      timer_reg <= 8'h00;
      sel_low_reg <= 1'b1;
      sclk_reg <= 1'b0;
      mosi_reg <= 1'b0;
      out_shift_reg <= 8'h00;
      in_shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      last_reg <= 1'b0;
    end else if (start) begin
      out_shift_reg <= pend_byte_reg;
      mosi_reg <= pend_byte_reg[7];
      last_reg <= pend_last_reg;
      bit_reg <= 3'h0;
      timer_reg <= HALF_CYC;
      state_reg <= HS_LOW;
    end else if (!tick) begin
      timer_reg <= timer_reg - 8'h01;
    end else begin
      unique case (state_reg)
        HS_IDLE: if (pend_reg) begin
          sel_low_reg <= 1'b0;
          timer_reg <= SETUP_CYC;
          state_reg <= HS_READY;
        end
        HS_READY, HS_GAP: ;
        HS_LOW: begin
          sclk_reg <= 1'b1;
          in_shift_reg <= {in_shift_reg[6:0], miso_sync[1]};
          timer_reg <= HALF_CYC;
          state_reg <= HS_HIGH;
        end
        HS_HIGH: begin
          sclk_reg <= 1'b0;
          if (bit_reg == 3'h7) begin
            // a burst or chained access continues while select stays low
            timer_reg <= last_reg ? HOLD_CYC : GAP_CYC;
            state_reg <= last_reg ? HS_HOLD : HS_GAP;
          end else begin
            bit_reg <= bit_reg + 3'h1;
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            mosi_reg <= out_shift_reg[6];
            timer_reg <= HALF_CYC;
            state_reg <= HS_LOW;
          end
        end
        HS_HOLD: begin
          sel_low_reg <= 1'b1;
          timer_reg <= REST_CYC;
          state_reg <= HS_REST;
        end
        HS_REST: state_reg <= HS_IDLE;
      endcase
    end
  end

  assign link.select_low = sel_low_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = mosi_reg;
  assign reg_rdata = rdata_reg;
endmodule

//--- spi_link_assertions.sv
/*
  Checker for the four serial wires between host and decoder.
  Assumes the bench places it beside spi_link_if, on the same clock.
*/
`timescale 1ns/1ps
module spi_link_assertions (
  input wire logic clock,
  input wire logic resetn,
  input wire logic select_low,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_reg, seen_reg, seen_next;
  logic [2:0] bits_reg, bits_next;
  logic [7:0] low_reg, low_next;
  wire logic rise = sclk & ~sclk_reg;

  // bit position in the byte, cycles since sclk fell (saturates)
  assign seen_next = !select_low && (seen_reg || rise);
  assign bits_next = select_low ? 3'h0 : bits_reg + {2'h0, rise};
  assign low_next = sclk ? 8'h00 : low_reg + {7'h00, low_reg != 8'hFF};

  // helper flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_reg <= 1'b0;
      seen_reg <= 1'b0;
      bits_reg <= 3'h0;
      low_reg <= 8'h00;
    end else begin
      sclk_reg <= sclk;
      seen_reg <= seen_next;
      bits_reg <= bits_next;
      low_reg <= low_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_idle_clock_low: assert property (select_low |-> !sclk)
    else $error("sclk high while deselected");
  a_wait_ready: assert property (rise && !seen_reg |-> !$past(miso))
    else $error("header clocked before ready went low");
  a_select_setup: assert property ($fell(select_low) |-> !sclk[*3])
    else $error("sclk rose too soon after select");
  a_mosi_steady: assert property (
    sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_miso_steady: assert property (
    sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk high");
  a_high_time: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("sclk high phase not eight cycles");
  a_whole_bytes: assert property (
    $rose(select_low) |-> bits_reg == 3'h0 && seen_reg)
    else $error("frame ended inside a byte");
  a_deselect_hold: assert property (
    $rose(select_low) |-> low_reg >= 8'h19)
    else $error("select rose too soon after last fall");

  // main traffic shapes
  c_frame_done: cover property ($rose(select_low) && seen_reg);
  c_last_bit: cover property (rise && bits_reg == 3'h7);
  c_ready_low: cover property (!select_low && !miso && !sclk);
endmodule

//--- tb_top.sv
/*
  Bench: host and decoder joined by spi_link_if; software talks to the
  host registers. Assumes a 125 MHz clock and reads answered next cycle.
*/
`timescale 1ns/1ps
module tb_top;
  import spi_access_pkg::*;
  localparam logic [7:0] RD_KEY = 8'hA5;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic chip_ready_low = 1'b0;
  logic [2:0] main_state = 3'h5;
  logic burst_autoinc_enable = 1'b1;
  logic direct_select = 1'b0;
  logic error_correction_enable = 1'b0;
  logic rx_fifo_empty = 1'b0;
  logic rx_push_valid = 1'b0;
  logic [7:0] rx_push_data = 8'h00;
  logic [7:0] acc_rdata = 8'h00;
  logic acc_valid, acc_write, strobe_valid;
  space_t acc_space;
  logic [7:0] acc_addr, acc_wdata;
  logic [5:0] strobe_code;
  int fails = 0;
  int tests_run = 0;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [19:0] acc_q[$];
  logic [5:0] stb_q[$];
  wire logic [7:0] status_exp = {chip_ready_low, main_state, STATUS_LOW_BITS};

  spi_link_if link();

  spi_access_host u_spi_access_host (.clock(clock), .resetn(resetn),
    .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

  spi_access_device u_spi_access_device (.clock(clock), .resetn(resetn),
    .link(link), .chip_ready_low(chip_ready_low), .main_state(main_state),
    .burst_autoinc_enable(burst_autoinc_enable),
    .direct_select(direct_select),
    .error_correction_enable(error_correction_enable),
    .rx_fifo_empty(rx_fifo_empty), .rx_push_valid(rx_push_valid),
    .rx_push_data(rx_push_data), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_space(acc_space), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .strobe_valid(strobe_valid), .strobe_code(strobe_code));

  spi_link_assertions u_spi_link_assertions (.clock(clock),
    .resetn(resetn), .select_low(link.select_low), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso));

  always #4 clock = ~clock;

  // user side: log requests, answer reads one cycle later
  always @(posedge clock) begin
    if (acc_valid === 1'b1) begin
      acc_q.push_back({acc_write, acc_space, acc_addr, acc_wdata});
      acc_rdata <= acc_addr ^ RD_KEY;
    end
    if (strobe_valid === 1'b1) stb_q.push_back(strobe_code);
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [19:0] seen,
                       input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_rx(input int i, input logic [7:0] e);
    check("rx byte", {12'h000, rx_q[i]}, {12'h000, e});
  endtask

  task automatic chk_acc(input logic w, input space_t sp,
                         input logic [7:0] a, input logic [7:0] d);
    logic [19:0] got;
    got = 20'hFFFFF;
    if (acc_q.size() > 0) got = acc_q.pop_front();
    check("access", got, {w, sp, a, d});
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask

  // bounded poll of the host status word
  task automatic wait_stat(input logic [15:0] m, input logic [15:0] v);
    logic [15:0] s;
    int n;
    n = 0;
    reg_rd(HOST_STAT_OFF, s);
    while ((s & m) !== v && n < 400) begin
      reg_rd(HOST_STAT_OFF, s);
      n++;
    end
    if (n >= 400) begin
      fails++;
      $display("MISMATCH host status expected %h seen %h", v, s & m);
      summarize();
    end
  endtask

  // one frame: every byte of tx_q, the last one closes it
  task automatic frame();
    logic [15:0] s;
    acc_q.delete();
    stb_q.delete();
    rx_q.delete();
    foreach (tx_q[i]) begin
      reg_wr(HOST_TX_OFF, {7'h00, i == tx_q.size() - 1, tx_q[i]});
      wait_stat(16'h0003, 16'h0002);
      reg_rd(HOST_RX_OFF, s);
      rx_q.push_back(s[7:0]);
    end
    // status bit2 reads back the select level: wait for it high again
    wait_stat(16'h0004, 16'h0004);
  endtask

  initial begin
    logic [15:0] s;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    reg_rd(4'hC, s);
    check("unmapped read", {4'h0, s}, 20'h00000);
    // single write, status back on both slots
    tx_q = '{8'h05, 8'h11};
    frame();
    chk_rx(0, status_exp);
    chk_rx(1, status_exp);
    check("acc count", 20'(acc_q.size()), 20'h00001);
    chk_acc(1'b1, SP_REG, 8'h05, 8'h11);
    // burst read runs into the last register and sticks
    tx_q = '{8'hEC, 8'h00, 8'h00, 8'h00, 8'h00};
    frame();
    chk_rx(1, 8'h2C ^ RD_KEY);
    chk_rx(2, 8'h2D ^ RD_KEY);
    chk_rx(3, 8'h2E ^ RD_KEY);
    chk_rx(4, 8'h2E ^ RD_KEY);
    // extended single write, zeros while the address goes out
    tx_q = '{8'h2F, 8'h3A, 8'h33};
    frame();
    chk_rx(0, status_exp);
    chk_rx(1, ZERO_BYTE);
    chk_rx(2, status_exp);
    chk_acc(1'b1, SP_EXT, 8'h3A, 8'h33);
    // extended burst wraps past the top of the map
    tx_q = '{8'h6F, 8'hFE, 8'h01, 8'h02, 8'h03};
    frame();
    for (int k = 0; k < 3; k++) begin
      chk_acc(1'b1, SP_EXT, 8'(8'hFE + k), 8'(k + 1));
    end
    // increment off: the burst keeps one register
    burst_autoinc_enable <= 1'b0;
    tx_q = '{8'h50, 8'h21, 8'h22};
    frame();
    chk_acc(1'b1, SP_REG, 8'h10, 8'h21);
    chk_acc(1'b1, SP_REG, 8'h10, 8'h22);
    burst_autoinc_enable <= 1'b1;
    // every strobe, both read flags, state shown in status
    for (int c = 8'h30; c <= 8'h3D; c++) begin
      main_state <= 3'(c);
      tx_q = '{{c[0], 1'b0, 6'(c)}};
      frame();
      chk_rx(0, status_exp);
      check("strobe", {14'h0000, stb_q[0]}, 20'(c));
      check("acc count", 20'(acc_q.size()), 20'h00000);
    end
    main_state <= 3'h5;
    // FIFO single write, then burst read
    tx_q = '{8'h3F, 8'h77};
    frame();
    chk_acc(1'b1, SP_FIFO, 8'h3F, 8'h77);
    tx_q = '{8'hFF, 8'h00, 8'h00, 8'h00};
    frame();
    for (int k = 1; k < 4; k++) begin
      chk_rx(k, 8'h3F ^ RD_KEY);
    end
    // direct bursts: select bit picks the target, address steps
    for (int m = 0; m < 2; m++) begin
      direct_select <= 1'(m);
      tx_q = '{8'h7E, 8'h7F, 8'h44, 8'h45};
      frame();
      check("acc count", 20'(acc_q.size()), 20'h00002);
      chk_acc(1'b1, m ? SP_FEC : SP_DIR_TX, 8'h7F, 8'h44);
      chk_acc(1'b1, m ? SP_FREE : SP_DIR_RX, 8'h80, 8'h45);
    end
    // workspace writes are dropped while error correction runs
    error_correction_enable <= 1'b1;
    tx_q = '{8'h3E, 8'h10, 8'h55};
    frame();
    check("acc count", 20'(acc_q.size()), 20'h00000);
    error_correction_enable <= 1'b0;
    tx_q = '{8'hBE, 8'h90, 8'h00};
    frame();
    chk_rx(2, 8'h90 ^ RD_KEY);
    // first byte into an empty receive FIFO, read back at 0xDA
    rx_fifo_empty <= 1'b1;
    rx_push_data <= 8'h9C;
    rx_push_valid <= 1'b1;
    @(posedge clock);
    rx_push_valid <= 1'b0;
    rx_fifo_empty <= 1'b0;
    tx_q = '{8'hAF, EXT_PREBUF, 8'h00};
    frame();
    chk_rx(2, 8'h9C);
    // host must hold its clock while the device reports not ready
    chip_ready_low <= 1'b1;
    reg_wr(HOST_TX_OFF, 16'h013D);
    repeat (60) @(posedge clock);
    reg_rd(HOST_STAT_OFF, s);
    check("held clock", {17'h00000, s[2:0]}, 20'h00001);
    chip_ready_low <= 1'b0;
    wait_stat(16'h0003, 16'h0002);
    reg_rd(HOST_RX_OFF, s);
    check("ready status", {12'h000, s[7:0]}, {12'h000, status_exp});
    wait_stat(16'h0004, 16'h0004);
    summarize();
  end
endmodule
